// ---- logic/icc_channel.sv ----
// Input capture channel with four-entry buffer, register port and interrupt
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "icc_consts.svh"

module icc_channel #(
    parameter int DEPTH = `ICC_FIFO_DEPTH
) (
    input  wire logic                 CLK_SYS,
    input  wire logic                 RST,
    input  wire icc_pkg::icc_bus_req_s BUS,
    output logic [15:0]               RDATA,
    input  wire logic                 CAPTURE_INPUT_PIN,
    input  wire logic [15:0]          TIMER_TWO_COUNT,
    input  wire logic [15:0]          TIMER_THREE_COUNT,
    input  wire logic                 CPU_IDLE,
    input  wire logic                 CPU_SLEEP,
    output logic                      IRQ,
    output logic                      WAKE
);
    import icc_pkg::*;

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    icc_ctrl_s    ctrl;
    icc_stat_t    stat;
    icc_stat_t    mask;
    icc_stat_t    set_evt;
    logic [2:0]   mode;
    logic         pin_s1;
    logic         pin_s2;
    logic         pin_d;
    logic         rise;
    logic         fall;
    logic         cpu_low;
    logic         halted;
    logic         mode_off;
    logic         wr_ctrl;
    logic         wr_stat;
    logic         wr_mask;
    logic         rd_buf;
    logic [3:0]   pre_cnt;
    logic         pre_last;
    logic         hit;
    logic         cap_evt;
    logic         push;
    logic         pop;
    logic         full;
    logic         not_empty;
    logic [15:0]  tstamp;
    logic [15:0]  head;
    logic [15:0]  mem [DEPTH];
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
    logic         ov;
    logic [1:0]   ici_cnt;
    logic         cap_irq;
    logic         pin_evt;
    logic [15:0]  ctrl_view;

    // Two-flop synchroniser, third flop only for edge detection
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_d  <= 1'b0;
        end else begin
            pin_s1 <= CAPTURE_INPUT_PIN;
            pin_s2 <= pin_s1;
            pin_d  <= pin_s2;
        end
    end

    // Edge and power-state decode
    assign rise     = pin_s2 & ~pin_d;
    assign fall     = ~pin_s2 & pin_d;
    assign cpu_low  = CPU_IDLE | CPU_SLEEP;
    assign mode     = ctrl.capture_mode_select;
    assign halted   = ctrl.idle_stop_select & CPU_IDLE;
    assign mode_off = (mode == `ICC_M_OFF) || (mode == `ICC_M_UNUSED);

    // Register port address decode
    assign wr_ctrl = BUS.wr && (BUS.addr == `ICC_OFS_CTRL);
    assign wr_stat = BUS.wr && (BUS.addr == `ICC_OFS_STAT);
    assign wr_mask = BUS.wr && (BUS.addr == `ICC_OFS_MASK);
    assign rd_buf  = BUS.rd && (BUS.addr == `ICC_OFS_BUF);

    // Control register; unimplemented and read-only bits not stored
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ctrl <= `ICC_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl.idle_stop_select       <= BUS.wdata[`ICC_B_SIDL];
            ctrl.timebase_select        <= BUS.wdata[`ICC_B_TMR];
            ctrl.captures_per_interrupt <= BUS.wdata[`ICC_B_CPI +: 2];
            ctrl.capture_mode_select    <= BUS.wdata[`ICC_B_MODE +: 3];
        end
    end

    // Rising-edge prescaler; restarted by any control write
    assign pre_last = ((mode == `ICC_M_DIV4) && (pre_cnt == `ICC_DIV4_LAST))
                   || ((mode == `ICC_M_DIV16) && (pre_cnt == `ICC_DIV16_LAST));
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            pre_cnt <= 4'h0;
        end else if (wr_ctrl || mode_off) begin
            pre_cnt <= 4'h0;
        end else if (!halted && rise &&
                     ((mode == `ICC_M_DIV4) || (mode == `ICC_M_DIV16))) begin
            pre_cnt <= pre_last ? 4'h0 : 4'(pre_cnt + 4'h1);
        end
    end

    // Capture event per mode
    always_comb begin
        case (mode)
            `ICC_M_EDGE:  hit = rise | fall;
            `ICC_M_FALL:  hit = fall;
            `ICC_M_RISE:  hit = rise;
            `ICC_M_DIV4:  hit = rise & pre_last;
            `ICC_M_DIV16: hit = rise & pre_last;
            default:      hit = 1'b0;
        endcase
    end
    assign cap_evt = hit & ~halted;

    // Buffer bookkeeping; a full buffer drops the new value
    assign full      = (cnt == CW'(DEPTH));
    assign not_empty = (cnt != '0);
    assign push      = cap_evt & ~full;
    assign pop       = rd_buf & not_empty;
    assign tstamp    = ctrl.timebase_select ? TIMER_TWO_COUNT
                                            : TIMER_THREE_COUNT;
    assign head      = mem[rp];

    // Capture storage, data only so no reset
    always_ff @(posedge CLK_SYS) begin
        if (push) begin
            mem[wp] <= tstamp;
        end
    end

    // Pointers wrap naturally, so depth must be a power of two
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else if (mode_off) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                wp <= PW'(wp + 1'b1);
            end
            if (pop) begin
                rp <= PW'(rp + 1'b1);
            end
            cnt <= CW'(cnt + CW'(push) - CW'(pop));
        end
    end

    // Overflow flag, cleared only by turning the channel off
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ov <= 1'b0;
        end else if (mode_off) begin
            ov <= 1'b0;
        end else if (cap_evt && full) begin
            ov <= 1'b1;
        end
    end

    // Captures-per-interrupt counter; bypassed in every-edge mode
    assign cap_irq = push && ((mode == `ICC_M_EDGE) ||
                     (ici_cnt == ctrl.captures_per_interrupt));
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ici_cnt <= 2'h0;
        end else if (wr_ctrl || mode_off) begin
            ici_cnt <= 2'h0;
        end else if (push && (mode != `ICC_M_EDGE)) begin
            ici_cnt <= (ici_cnt == ctrl.captures_per_interrupt) ?
                       2'h0 : 2'(ici_cnt + 2'h1);
        end
    end

    // Pin-interrupt mode only listens while the CPU is asleep or idle
    assign pin_evt = (mode == `ICC_M_PININT) && rise && cpu_low;

    // Wake request pulse
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            WAKE <= 1'b0;
        end else begin
            WAKE <= pin_evt | (cap_irq & cpu_low);
        end
    end

    // Sticky status, set beats a same-cycle write-one clear
    always_comb begin
        set_evt = '0;
        set_evt[`ICC_S_CAP] = cap_irq;
        set_evt[`ICC_S_OV]  = cap_evt & full;
        set_evt[`ICC_S_PIN] = pin_evt;
    end
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            stat <= `ICC_STAT_RST;
        end else begin
            stat <= set_evt | (stat & ~(wr_stat ? BUS.wdata[2:0] : 3'h0));
        end
    end

    // Mask register
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            mask <= `ICC_MASK_RST;
        end else if (wr_mask) begin
            mask <= BUS.wdata[2:0];
        end
    end

    // Level interrupt, registered so it lags status by one cycle
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(stat & mask);
        end
    end

    // Control readback; unused bits stay zero
    always_comb begin
        ctrl_view = 16'h0000;
        ctrl_view[`ICC_B_SIDL]       = ctrl.idle_stop_select;
        ctrl_view[`ICC_B_TMR]        = ctrl.timebase_select;
        ctrl_view[`ICC_B_CPI +: 2]   = ctrl.captures_per_interrupt;
        ctrl_view[`ICC_B_OV]         = ov;
        ctrl_view[`ICC_B_BNE]        = not_empty;
        ctrl_view[`ICC_B_MODE +: 3]  = mode;
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            RDATA <= 16'h0000;
        end else if (!BUS.rd) begin
            RDATA <= 16'h0000;
        end else if (BUS.addr == `ICC_OFS_CTRL) begin
            RDATA <= ctrl_view;
        end else if (BUS.addr == `ICC_OFS_BUF) begin
            RDATA <= not_empty ? head : 16'h0000;
        end else if (BUS.addr == `ICC_OFS_STAT) begin
            RDATA <= {13'h0000, stat};
        end else if (BUS.addr == `ICC_OFS_MASK) begin
            RDATA <= {13'h0000, mask};
        end else begin
            RDATA <= 16'h0000;
        end
    end

    // Checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    ctrl_rsvd_a: assert property (BUS.rd && BUS.addr == `ICC_OFS_CTRL |=>
        RDATA[15:14] == 2'h0 && RDATA[12:8] == 5'h00) else $error("reserved bits set");
    bne_read_a: assert property (BUS.rd && BUS.addr == `ICC_OFS_CTRL |=>
        RDATA[`ICC_B_BNE] == $past(not_empty)) else $error("buffer flag wrong");
    off_clear_a: assert property (mode_off |=> !ov && cnt == '0)
        else $error("off mode kept state");
    ov_set_a: assert property (cap_evt && full |=> ov && stat[`ICC_S_OV])
        else $error("overflow not flagged");
    stamp_a: assert property (push |=> mem[$past(wp)] == $past(tstamp))
        else $error("wrong timer stored");
    fall_only_a: assert property (mode == `ICC_M_FALL && !halted |-> cap_evt == fall)
        else $error("falling capture wrong");
    rise_only_a: assert property (mode == `ICC_M_RISE && !halted |-> cap_evt == rise)
        else $error("rising capture wrong");
    every_edge_a: assert property (mode == `ICC_M_EDGE && (rise || fall) && !halted
        && !full |-> cap_irq) else $error("edge capture lost");
    idle_halt_a: assert property (halted |-> !cap_evt)
        else $error("capture while halted");
    // A control write restarts the prescaler even when halted, so it is excused here
    idle_hold_a: assert property (halted && !wr_ctrl |=> $stable(pre_cnt))
        else $error("prescaler moved while halted");
    div4_a: assert property (mode == `ICC_M_DIV4 && cap_evt |-> pre_cnt == `ICC_DIV4_LAST)
        else $error("div4 capture early");
    div16_a: assert property (mode == `ICC_M_DIV16 && cap_evt |->
        pre_cnt == `ICC_DIV16_LAST) else $error("div16 capture early");
    cap_irq_a: assert property (push && mode != `ICC_M_EDGE |->
        cap_irq == (ici_cnt == ctrl.captures_per_interrupt)) else $error("irq count wrong");
    every_cap_a: assert property (push && ctrl.captures_per_interrupt == 2'h0 |->
        cap_irq) else $error("single capture irq lost");
    pin_wake_a: assert property (pin_evt |=> WAKE && stat[`ICC_S_PIN])
        else $error("pin wake missing");
    fifo_order_a: assert property (pop |=> RDATA == $past(head))
        else $error("buffer order wrong");
    irq_out_a: assert property (|(stat & mask) |=> IRQ)
        else $error("interrupt not raised");

    fill_c: cover property (push && cnt == CW'(DEPTH - 1));
    over_c: cover property (cap_evt && full);
    pin_c: cover property (pin_evt);
    div16_c: cover property (mode == `ICC_M_DIV16 && cap_evt);

endmodule : icc_channel

// ---- inc/icc_consts.svh ----
// Offsets, field positions, reset values and counts of the capture channel
`ifndef ICC_CONSTS_SVH
`define ICC_CONSTS_SVH
`define ICC_OFS_CTRL   8'h00
`define ICC_OFS_BUF    8'h04
`define ICC_OFS_STAT   8'h08
`define ICC_OFS_MASK   8'h0C
`define ICC_B_SIDL     13
`define ICC_B_TMR      7
`define ICC_B_CPI      5
`define ICC_B_OV       4
`define ICC_B_BNE      3
`define ICC_B_MODE     0
`define ICC_S_CAP      0
`define ICC_S_OV       1
`define ICC_S_PIN      2
`define ICC_CTRL_RST   7'h00
`define ICC_STAT_RST   3'h0
`define ICC_MASK_RST   3'h0
`define ICC_M_OFF      3'h0
`define ICC_M_EDGE     3'h1
`define ICC_M_FALL     3'h2
`define ICC_M_RISE     3'h3
`define ICC_M_DIV4     3'h4
`define ICC_M_DIV16    3'h5
`define ICC_M_UNUSED   3'h6
`define ICC_M_PININT   3'h7
`define ICC_DIV4_LAST  4'h3
`define ICC_DIV16_LAST 4'hF
`define ICC_FIFO_DEPTH 4
`endif

// ---- inc/icc_pkg.sv ----
// Types shared by the capture channel
package icc_pkg;
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } icc_bus_req_s;
    typedef struct packed {
        logic       idle_stop_select;
        logic       timebase_select;
        logic [1:0] captures_per_interrupt;
        logic [2:0] capture_mode_select;
    } icc_ctrl_s;
    typedef logic [2:0] icc_stat_t;
endpackage : icc_pkg

// ---- test/icc_pin_model.sv ----
// Behavioural source driving the capture input pin
`timescale 1ns/1ps
module icc_pin_model #(
    parameter int HOLD = 4
) (
    input  wire logic clk_sys,
    output logic      pin
);
    // Pin rests low until the first toggle
    initial pin = 1'b0;

    // Each level stands HOLD clocks, since the synchroniser misses short pulses
    task automatic toggle();
        pin <= ~pin;
        repeat (HOLD) @(posedge clk_sys);
    endtask : toggle
endmodule : icc_pin_model

// ---- test/tb.sv ----
// Self-checking bench of the capture channel against a queue model
`timescale 1ns/1ps
`include "icc_consts.svh"
module tb;
    import icc_pkg::*;
    logic         clk_sys = 1'b0;
    logic         rst     = 1'b1;
    icc_bus_req_s bus     = '0;
    logic [15:0]  rdata;
    logic         pin;
    logic [15:0]  t2      = 16'h0000;
    logic [15:0]  t3      = 16'h0000;
    logic         idle    = 1'b0;
    logic         sleep   = 1'b0;
    logic         irq;
    logic         wake;
    logic         woke    = 1'b0;
    logic [31:0]  seed    = 32'hCDD9;
    int           fails   = 0;
    int           checks  = 0;
    logic [15:0]  q[$];
    logic [2:0]   stat    = 3'h0;
    logic         ovf     = 1'b0;
    int           pre;
    int           cnt;
    logic [15:0]  d;
    // Rows: mode, timebase, per-interrupt, stop-in-idle, idle, sleep, toggles, mask
    int tab [13][8] = '{'{3,1,0,0,0,0,4,7}, '{2,0,1,0,0,0,6,7}, '{1,1,3,0,0,0,2,7},
        '{3,0,2,0,0,0,12,3}, '{0,0,0,0,0,0,4,7}, '{4,0,0,0,0,0,10,7},
        '{5,1,0,0,0,0,34,7}, '{6,1,0,0,0,0,4,7}, '{3,1,0,1,1,0,4,7},
        '{3,1,0,0,1,0,4,7}, '{7,0,0,0,0,1,4,7}, '{7,0,0,0,0,0,4,7},
        '{2,1,0,0,0,0,4,0}};

    // 50 MHz system clock
    always #10 clk_sys = ~clk_sys;
    // Wake is a one-cycle pulse, so latch it for a later look
    always @(posedge clk_sys) if (wake === 1'b1) woke <= 1'b1;

    icc_channel icc_channel_inst (.CLK_SYS(clk_sys), .RST(rst), .BUS(bus), .RDATA(rdata),
        .CAPTURE_INPUT_PIN(pin), .TIMER_TWO_COUNT(t2), .TIMER_THREE_COUNT(t3),
        .CPU_IDLE(idle), .CPU_SLEEP(sleep), .IRQ(irq), .WAKE(wake));
    icc_pin_model icc_pin_model_inst (.clk_sys(clk_sys), .pin(pin));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    function automatic logic [15:0] ctl(input int r[8]);
        return {2'b00, r[3][0], 5'h00, r[1][0], r[2][1:0], ovf, q.size() != 0, r[0][2:0]};
    endfunction : ctl

    task automatic cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_word

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        cmp_word(nm, {15'h0000, e}, {15'h0000, g});
    endtask : cmp_bit

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask : rd

    // One pin edge with fresh timer values held while the capture lands
    task automatic evt(input int mode, input int tmr, input int cpi, input logic halt);
        logic rise;
        logic cap;
        @(posedge clk_sys);
        seed = xs(seed);
        t2 <= seed[15:0];
        t3 <= seed[31:16];
        rise = ~pin;
        cap = 1'b0;
        if (mode == 7) begin
            if (rise && (idle || sleep)) stat[2] = 1'b1;
        end else if (!halt && mode != 0 && mode != 6) begin
            cap = mode == 1 || (mode == 2 && !rise) || (mode == 3 && rise);
            if (rise && mode >= 4) begin
                pre++;
                cap = pre % (mode == 4 ? 4 : 16) == 0;
            end
        end
        if (cap && q.size() == `ICC_FIFO_DEPTH) begin
            ovf = 1'b1;
            stat[1] = 1'b1;
        end else if (cap) begin
            q.push_back(tmr != 0 ? seed[15:0] : seed[31:16]);
            cnt++;
            if (mode == 1 || cnt == cpi + 1) begin
                stat[0] = 1'b1;
                cnt = 0;
            end
        end
        icc_pin_model_inst.toggle();
    endtask : evt

    task automatic run(input int r[8]);
        logic [15:0] v;
        wr(`ICC_OFS_MASK, 16'(r[7]));
        wr(`ICC_OFS_CTRL, {2'b11, r[3][0], 5'h1F, r[1][0], r[2][1:0], 2'b11, r[0][2:0]});
        pre = 0;
        cnt = 0;
        if (r[0] == 0 || r[0] == 6) begin
            q.delete();
            ovf = 1'b0;
        end
        wr(`ICC_OFS_STAT, 16'h0007);
        stat = 3'h0;
        idle <= r[4][0];
        sleep <= r[5][0];
        woke <= 1'b0;
        repeat (r[6]) evt(r[0], r[1], r[2], r[3] != 0 && r[4] != 0);
        repeat (8) @(posedge clk_sys);
        #1;
        cmp_bit("irq", |(stat & r[7][2:0]), irq);
        cmp_bit("wake", (r[4] != 0 || r[5] != 0) && (stat[0] || stat[2]), woke);
        rd(`ICC_OFS_STAT, v);
        cmp_word("status", {13'h0000, stat}, v);
        rd(`ICC_OFS_CTRL, v);
        cmp_word("control", ctl(r), v);
        while (q.size() > 0) begin
            rd(`ICC_OFS_BUF, v);
            cmp_word("capture", q.pop_front(), v);
        end
        rd(`ICC_OFS_BUF, v);
        cmp_word("empty read", 16'h0000, v);
        rd(`ICC_OFS_CTRL, v);
        cmp_word("drained control", ctl(r), v);
    endtask : run

    task automatic results();
        $display("Checks %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results

    // Main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        rd(8'h10, d);
        cmp_word("unmapped read", 16'h0000, d);
        wr(8'h14, 16'hFFFF);
        rd(`ICC_OFS_CTRL, d);
        cmp_word("reset control", 16'h0000, d);
        foreach (tab[i]) begin
            run(tab[i]);
            $display("Test %0d done", i);
        end
        results();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        results();
    end
endmodule : tb
